// >>> rtl/cbrc_pkg.sv
// shared constants and types for the control block register slave
package cbrc_pkg;
  localparam int unsigned ADDR_W      = 32;
  localparam int unsigned DATA_W      = 64;
  localparam int unsigned CTRL_BLK_OFF_W = 24;
  localparam int unsigned SLOT_IDX_W  = 4;
  localparam int unsigned SLOT_COUNT  = 16;
  localparam int unsigned SLOT_LSB    = 3;
  localparam int unsigned FLAG_W      = 8;
  localparam int unsigned MERR_LSB    = 8;
  localparam int unsigned VERS_LSB    = 16;
  localparam int unsigned ID_LSB      = 32;
  localparam int unsigned BOT_LSB     = 48;
  localparam int unsigned TOP_LSB     = 56;
  localparam int unsigned WIDE_SZ     = 8;
  localparam int unsigned NARROW_SZ   = 4;
  localparam logic [7:0]  RECEIVE_ERROR_BIT = 8'h00;
  localparam logic [7:0]  ERR_UNDEF_BIT = 8'h01;
  localparam logic [7:0]  ERR_ALIGN_BIT = 8'h02;
  localparam logic [7:0]  ERR_UBLK_BIT  = 8'h03;
  localparam logic [7:0]  PERR_IMPL_MASK = 8'h0f;
  localparam logic [23:0] VERSION_REG_OFF = 24'h00_0000;
  localparam logic [23:0] CTRL_OFF    = 24'h00_0008;
  localparam logic [23:0] STAT_OFF    = 24'h00_0010;
  localparam logic [23:0] UNDEF_LO    = 24'h00_0040;
  localparam logic [23:0] UNDEF_HI    = 24'h00_007f;
  localparam logic [63:0] UNDEF_READ  = 64'hdead_0000_0000_dead;
  localparam logic [63:0] CTRL_RW_MASK = 64'h0000_0000_ffff_ffff;
  localparam logic [63:0] ZERO64      = 64'h0000_0000_0000_0000;

  typedef enum logic [1:0] {CBRC_BLK_CTRL, CBRC_BLK_DATA, CBRC_BLK_UNDEF} cbrc_blk_t;
  typedef enum logic [1:0] {CBRC_SLOT_RES, CBRC_SLOT_UNDEF, CBRC_SLOT_DEF} cbrc_slot_t;

  typedef struct packed {
    logic        valid;
    logic        store;
    logic        wide;
    logic [31:0] addr;
    logic [63:0] wdata;
  } cbrc_req_t;

  typedef struct packed {
    logic        valid;
    logic        error;
    logic [63:0] rdata;
  } cbrc_rsp_t;
endpackage

// >>> rtl/cbrc_decode.sv
// address decode into block class and register slot class
`timescale 1ns/1ps
module cbrc_decode #(
  parameter logic [31:0] CTRL_BLK_BASE  = 32'h1000_0000,
  parameter logic [31:0] DATA_BLK_BASE  = 32'h2000_0000,
  parameter logic [31:0] DATA_BLK_LIMIT = 32'h2fff_ffff
) (
  input  wire logic [31:0]        addr,
  input  wire logic               wide,
  output cbrc_pkg::cbrc_blk_t     blk,
  output cbrc_pkg::cbrc_slot_t    slot,
  output logic [23:0]             offset,
  output logic                    misaligned
);
  always_comb
  begin
    offset = addr[23:0];
    // control block spans a full 16 Mbyte window above its base
    if (addr[31:24] == CTRL_BLK_BASE[31:24])
      blk = cbrc_pkg::CBRC_BLK_CTRL;
    else if (addr >= DATA_BLK_BASE && addr <= DATA_BLK_LIMIT)
      blk = cbrc_pkg::CBRC_BLK_DATA;
    else
      blk = cbrc_pkg::CBRC_BLK_UNDEF;
    misaligned = wide ? (addr[2:0] != 3'h0) : (addr[1:0] != 2'h0);
    // build-time slot table
    if (offset[23:3] == cbrc_pkg::VERSION_REG_OFF[23:3]
        || offset[23:3] == cbrc_pkg::CTRL_OFF[23:3]
        || offset[23:3] == cbrc_pkg::STAT_OFF[23:3])
      slot = cbrc_pkg::CBRC_SLOT_DEF;
    else if (offset >= cbrc_pkg::UNDEF_LO && offset <= cbrc_pkg::UNDEF_HI)
      slot = cbrc_pkg::CBRC_SLOT_UNDEF;
    else
      slot = cbrc_pkg::CBRC_SLOT_RES;
  end
endmodule

// >>> rtl/cbrc_slave.sv
// control block register slave with version control register and error flags
// Behaviour
// - classify blocks; undefined block requests go to debug
// - one control block per module
// - data blocks contiguous, no version register
// - registers 32 or 64 bit, naturally aligned
// - control block decodes a 16 Mbyte space
// - whole word load and store accesses
// - reserved slot reads zero, ignores writes
// - undefined register request sets error flag
// - undefined response may set receiver flag
// - undefined read gives fixed value, write ignored
// - every defined bit belongs to one field
// - reserved field reads zero, writes discarded
// - read-only field returns value, ignores writes
// - read/write field stores written value
// - hardware changes only volatile fields
// - writable fields may start undefined
// - bit 0 least, bit 63 most significant
// - offset is byte offset from block base
// - offset zero holds nonzero version register
// - error flags reset zero, hardware sets
`timescale 1ns/1ps
module cbrc_slave #(
  parameter logic [15:0] MOD_VERS = 16'h0001,  // arbitrary value
  parameter logic [15:0] MOD_ID   = 16'h00a5,  // arbitrary value
  parameter logic [7:0]  BOT_MB   = 8'h20,
  parameter logic [7:0]  TOP_MB   = 8'h2f
) (
  input  wire logic                  mclk,
  input  wire logic                  resetn,
  input  wire cbrc_pkg::cbrc_req_t   req,
  output logic                       req_ready,
  output cbrc_pkg::cbrc_rsp_t        rsp,
  input  wire logic                  rsp_in_valid,
  input  wire logic                  rsp_in_error,
  output logic                       debug_err,
  output logic [31:0]                debug_addr,
  output logic                       data_block_valid,
  output logic [31:0]                data_block_addr,
  output logic [31:0]                ctrl_out,
  input  wire logic [31:0]           stat_in
);
  cbrc_pkg::cbrc_blk_t  blk;
  cbrc_pkg::cbrc_slot_t slot;
  logic [23:0]          offset;
  logic                 misaligned;
  logic [7:0]           perr_reg;
  logic [7:0]           perr_next;
  logic [7:0]           merr_reg;
  logic [31:0]          ctrl_reg;
  logic [31:0]          stat_reg;
  logic [63:0]          rdata_next;
  logic                 err_next;
  logic                 ctrl_hit;
  logic                 wr_ok;
  logic                 undef_blk_req;
  logic                 data_blk_req;
  logic                 low_half;
  logic                 version_hit;
  logic                 ctrl_word_hit;
  logic                 stat_word_hit;
  logic                 flag_load;
  logic [7:0]           flag_wdata;
  logic                 set_receive;
  logic                 set_undef_slot;
  logic                 set_align;
  logic                 set_undef_blk;
  logic [63:0]          version_value;
  logic [63:0]          ctrl_value;
  logic [63:0]          stat_value;
  logic [63:0]          slot_word;
  logic                 rsp_valid_reg;
  logic                 rsp_error_reg;
  logic [63:0]          rsp_rdata_reg;

  cbrc_decode u_decode (
    .addr       (req.addr),
    .wide       (req.wide),
    .blk        (blk),
    .slot       (slot),
    .offset     (offset),
    .misaligned (misaligned)
  );

  function automatic logic [63:0] version_word(input logic [7:0] perr, input logic [7:0] merr);
    version_word = {TOP_MB, BOT_MB, MOD_ID, MOD_VERS, merr, perr};
  endfunction

  // offsets name one slot when they agree above the byte lanes of a wide register
  function automatic logic slot_match(input logic [23:0] off, input logic [23:0] slot_off);
    slot_match = off[23:cbrc_pkg::SLOT_LSB] == slot_off[23:cbrc_pkg::SLOT_LSB];
  endfunction

  // a narrow load of the upper word of a slot returns that half in the low lanes
  function automatic logic [63:0] lane_select(input logic [63:0] word, input logic wide,
                                              input logic upper);
    if (!wide && upper)
      lane_select = {32'h0000_0000, word[63:32]};
    else
      lane_select = word;
  endfunction

  assign req_ready     = 1'b1;
  assign ctrl_hit      = req.valid && blk == cbrc_pkg::CBRC_BLK_CTRL && !misaligned;
  assign wr_ok         = ctrl_hit && req.store && slot == cbrc_pkg::CBRC_SLOT_DEF;
  assign ctrl_out      = ctrl_reg;
  assign undef_blk_req = req.valid && blk == cbrc_pkg::CBRC_BLK_UNDEF;
  assign data_blk_req  = req.valid && blk == cbrc_pkg::CBRC_BLK_DATA;
  assign low_half      = !offset[2];
  assign version_hit   = slot_match(offset, cbrc_pkg::VERSION_REG_OFF);
  assign ctrl_word_hit = slot_match(offset, cbrc_pkg::CTRL_OFF);
  assign stat_word_hit = slot_match(offset, cbrc_pkg::STAT_OFF);

  // error events; a single request fires at most one of them, a receive error may fire alongside it
  assign set_receive    = rsp_in_valid && rsp_in_error;
  assign set_undef_slot = ctrl_hit && slot == cbrc_pkg::CBRC_SLOT_UNDEF;
  assign set_align      = req.valid && misaligned && blk == cbrc_pkg::CBRC_BLK_CTRL;
  assign set_undef_blk  = undef_blk_req;
  assign flag_load      = wr_ok && version_hit && low_half;
  assign flag_wdata     = req.wdata[7:0] & cbrc_pkg::PERR_IMPL_MASK;

  // field images of the defined registers; control and status upper words are reserved and read zero
  assign version_value = version_word(perr_reg, merr_reg);
  assign ctrl_value    = {32'h0000_0000, ctrl_reg};
  assign stat_value    = {32'h0000_0000, stat_reg};

  // defined slot select; the slot table guarantees exactly one of the three hits
  always_comb
  begin
    slot_word = stat_value;
    if (version_hit)
      slot_word = version_value;
    else if (ctrl_word_hit)
      slot_word = ctrl_value;
  end

  // read mux per slot class, answered one cycle after the request
  always_comb
  begin
    rdata_next = cbrc_pkg::ZERO64;
    err_next   = 1'b0;
    if (undef_blk_req)
      err_next = 1'b1;
    else if (req.valid && misaligned)
      err_next = 1'b1;
    else if (ctrl_hit && !req.store)
    begin
      unique case (slot)
        cbrc_pkg::CBRC_SLOT_RES:
          rdata_next = cbrc_pkg::ZERO64;
        cbrc_pkg::CBRC_SLOT_UNDEF:
          rdata_next = cbrc_pkg::UNDEF_READ;
        cbrc_pkg::CBRC_SLOT_DEF:
          rdata_next = slot_word;
        default:
          rdata_next = cbrc_pkg::ZERO64;
      endcase
      rdata_next = lane_select(rdata_next, req.wide, !low_half);
    end
  end

  // error flag update: a hardware set beats a software clear in the same cycle
  always_comb
  begin
    perr_next = perr_reg;
    if (flag_load)
      perr_next = flag_wdata;
    if (set_undef_slot)
      perr_next[cbrc_pkg::ERR_UNDEF_BIT[2:0]] = 1'b1;
    if (set_align)
      perr_next[cbrc_pkg::ERR_ALIGN_BIT[2:0]] = 1'b1;
    if (set_receive)
      perr_next[cbrc_pkg::RECEIVE_ERROR_BIT[2:0]] = 1'b1;
    if (set_undef_blk)
      perr_next[cbrc_pkg::ERR_UBLK_BIT[2:0]] = 1'b1;
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      perr_reg <= 8'h00;
    else
      perr_reg <= perr_next;
  end

  // module specific flags: none implemented, field held at zero
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      merr_reg <= 8'h00;
    else
      merr_reg <= 8'h00;
  end

  // read/write control word; reset given anyway, cheaper than x-tracking
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      ctrl_reg <= 32'h0000_0000;
    else if (wr_ok && ctrl_word_hit && low_half)
      ctrl_reg <= req.wdata[31:0] & cbrc_pkg::CTRL_RW_MASK[31:0];
  end

  // volatile read-only status sampled from the module core every cycle
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      stat_reg <= 32'h0000_0000;
    else
      stat_reg <= stat_in;
  end

  // response strobe: data block requests are answered by the block's owner instead
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      rsp_valid_reg <= 1'b0;
    else
      rsp_valid_reg <= req.valid && blk != cbrc_pkg::CBRC_BLK_DATA;
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      rsp_error_reg <= 1'b0;
    else
      rsp_error_reg <= err_next;
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      rsp_rdata_reg <= cbrc_pkg::ZERO64;
    else
      rsp_rdata_reg <= rdata_next;
  end

  assign rsp = '{valid: rsp_valid_reg, error: rsp_error_reg, rdata: rsp_rdata_reg};

  // undefined block requests are handed to the debug recorder
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      debug_err <= 1'b0;
    else
      debug_err <= undef_blk_req;
  end

  // the address holds until the next such request so the recorder may pick it up late
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      debug_addr <= 32'h0000_0000;
    else if (undef_blk_req)
      debug_addr <= req.addr;
  end

  // data block accesses pass on; they never see the version register
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      data_block_valid <= 1'b0;
    else
      data_block_valid <= data_blk_req;
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      data_block_addr <= 32'h0000_0000;
    else if (data_blk_req)
      data_block_addr <= req.addr;
  end
endmodule

// >>> dv/cbrc_slave_sva.sv
// assertions for the control block register slave
`timescale 1ns/1ps
module cbrc_slave_sva (
  input wire logic                mclk,
  input wire logic                resetn,
  input wire cbrc_pkg::cbrc_req_t req,
  input wire logic                req_ready,
  input wire cbrc_pkg::cbrc_rsp_t rsp,
  input wire logic                rsp_in_valid,
  input wire logic                rsp_in_error,
  input wire logic                debug_err,
  input wire logic [31:0]         debug_addr,
  input wire logic                data_block_valid,
  input wire logic [31:0]         data_block_addr,
  input wire logic [31:0]         ctrl_out,
  input wire logic [31:0]         stat_in
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  wire        ctl_req = req.valid && req.addr[31:24] == 8'h10;
  wire        ld = ctl_req && !req.store && req.wide && req.addr[2:0] == 3'h0;
  wire        und_req = req.valid && req.addr[31:24] != 8'h10 && req.addr[31:28] != 4'h2;
  wire [31:0] ra = req.addr;
  wire [31:0] wl = req.wdata[31:0];
  property p_rdy; req_ready; endproperty
  a_rdy: assert property (p_rdy) else $error("ready low");
  property p_version; ld && ra[23:0] == 24'h0 |=> rsp.valid && rsp.rdata[63:16] != 48'h0;
  endproperty
  a_version: assert property (p_version) else $error("version word zero");
  property p_res; ld && ra[23:7] != 17'h0 |=> rsp.rdata == 64'h0 && !rsp.error; endproperty
  a_res: assert property (p_res) else $error("reserved slot nonzero");
  property p_und; ld && ra[23:6] == 18'h1 |=> rsp.rdata == cbrc_pkg::UNDEF_READ; endproperty
  a_und: assert property (p_und) else $error("undefined slot value");
  property p_ublk; und_req |=> debug_err && rsp.error && debug_addr == $past(ra); endproperty
  a_ublk: assert property (p_ublk) else $error("undefined block not reported");
  property p_dblk; req.valid && ra[31:28] == 4'h2 |=>
    data_block_valid && !rsp.valid && data_block_addr == $past(ra);
  endproperty
  a_dblk: assert property (p_dblk) else $error("data block not forwarded");
  property p_mis; ctl_req && !req.wide && ra[1:0] != 2'h0 |=> rsp.valid && rsp.error; endproperty
  a_mis: assert property (p_mis) else $error("misaligned accepted");
  property p_wr; ctl_req && req.store && ra[23:0] == 24'h8 |=> ctrl_out == $past(wl); endproperty
  a_wr: assert property (p_wr) else $error("control word not stored");
  property p_keep; !(ctl_req && req.store && ra[23:0] == 24'h8) |=> $stable(ctrl_out);
  endproperty
  a_keep: assert property (p_keep) else $error("control word changed");
  property p_st; ld && ra[23:0] == 24'h10 |=> rsp.rdata == {32'h0, $past(stat_in, 2)};
  endproperty
  a_st: assert property (p_st) else $error("status value wrong");
endmodule
bind cbrc_slave cbrc_slave_sva u_sva (
  .mclk(mclk), .resetn(resetn), .req(req), .req_ready(req_ready), .rsp(rsp),
  .rsp_in_valid(rsp_in_valid), .rsp_in_error(rsp_in_error), .debug_err(debug_err),
  .debug_addr(debug_addr), .data_block_valid(data_block_valid),
  .data_block_addr(data_block_addr),
  .ctrl_out(ctrl_out), .stat_in(stat_in)
);

// >>> dv/cbrc_fabric.sv
// interconnect-side model issuing word requests to the slave
`timescale 1ns/1ps
module cbrc_fabric (
  input  wire logic                mclk,
  input  wire cbrc_pkg::cbrc_rsp_t rsp,
  output cbrc_pkg::cbrc_req_t      req,
  output logic                     rsp_in_valid,
  output logic                     rsp_in_error
);
  initial
  begin
    req = '0;
    rsp_in_valid = 1'b0;
    rsp_in_error = 1'b0;
  end
  task automatic issue(input logic st, input logic wd, input logic [31:0] a,
                       input logic [63:0] d, output cbrc_pkg::cbrc_rsp_t r);
    @(posedge mclk);
    req <= '{valid: 1'b1, store: st, wide: wd, addr: a, wdata: d};
    @(posedge mclk);
    // released lines flip so a stale request is never mistaken for a live one
    req <= '{valid: 1'b0, store: ~st, wide: ~wd, addr: ~a, wdata: ~d};
    #1 r = rsp;
  endtask
  task automatic pulse_err();
    @(posedge mclk);
    rsp_in_valid <= 1'b1;
    rsp_in_error <= 1'b1;
    @(posedge mclk);
    rsp_in_valid <= 1'b0;
    rsp_in_error <= 1'b0;
  endtask
endmodule

// >>> dv/tb.sv
// self-checking bench for the control block register slave
`timescale 1ns/1ps
module tb;
  localparam logic [31:0] CTRL_BASE = 32'h1000_0000;
  logic                mclk;
  logic                resetn;
  logic [31:0]         stat_in;
  cbrc_pkg::cbrc_req_t req;
  cbrc_pkg::cbrc_rsp_t rsp;
  cbrc_pkg::cbrc_rsp_t r;
  logic                rsp_in_valid;
  logic                rsp_in_error;
  logic                debug_err;
  logic [31:0]         debug_addr;
  logic                data_block_valid;
  logic [31:0]         data_block_addr;
  logic [31:0]         ctrl_out;
  int                  miscompares = 0;
  int                  n_tests = 0;
  cbrc_slave uut (.mclk(mclk), .resetn(resetn), .req(req), .req_ready(), .rsp(rsp),
    .rsp_in_valid(rsp_in_valid), .rsp_in_error(rsp_in_error), .debug_err(debug_err),
    .debug_addr(debug_addr), .data_block_valid(data_block_valid),
    .data_block_addr(data_block_addr), .ctrl_out(ctrl_out), .stat_in(stat_in));
  cbrc_fabric fab (.mclk(mclk), .rsp(rsp), .req(req), .rsp_in_valid(rsp_in_valid),
    .rsp_in_error(rsp_in_error));
  initial
  begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    n_tests++;
    if (g !== e)
    begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic summarize();
    if (miscompares == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic t_version(input logic [7:0] f);
    fab.issue(1'b0, 1'b1, CTRL_BASE, 64'h0, r);
    chk("version", {48'h2f20_00a5_0001, 8'h00, f}, r.rdata);
  endtask
  task automatic t_ctrl();
    fab.issue(1'b1, 1'b1, CTRL_BASE + 32'h8, 64'hffff_ffff_1234_5678, r);
    chk("ctrl_out", 64'h1234_5678, {32'h0, ctrl_out});
    fab.issue(1'b0, 1'b1, CTRL_BASE + 32'h8, 64'h0, r);
    chk("ctrl", 64'h1234_5678, r.rdata);
    // narrow store to the upper half of the control slot has no effect
    fab.issue(1'b1, 1'b0, CTRL_BASE + 32'hc, 64'h0, r);
    chk("ctrl_out", 64'h1234_5678, {32'h0, ctrl_out});
    fab.issue(1'b0, 1'b0, CTRL_BASE + 32'h4, 64'h0, r);
    chk("version_hi", 64'h2f20_00a5, r.rdata);
  endtask
  task automatic t_stat();
    @(posedge mclk);
    stat_in <= 32'hcafe_f00d;
    fab.issue(1'b1, 1'b1, CTRL_BASE + 32'h10, '1, r);
    fab.issue(1'b0, 1'b1, CTRL_BASE + 32'h10, 64'h0, r);
    chk("stat", 64'hcafe_f00d, r.rdata);
  endtask
  task automatic t_slots();
    fab.issue(1'b1, 1'b1, CTRL_BASE + 32'h80, 64'h0, r);
    fab.issue(1'b0, 1'b1, CTRL_BASE + 32'hff_fff8, 64'h0, r);
    chk("reserved", 64'h0, r.rdata);
    fab.issue(1'b1, 1'b1, CTRL_BASE + 32'h48, '1, r);
    fab.issue(1'b0, 1'b1, CTRL_BASE + 32'h40, 64'h0, r);
    chk("undef", cbrc_pkg::UNDEF_READ, r.rdata);
    chk("ctrl_out", 64'h1234_5678, {32'h0, ctrl_out});
    t_version(8'h02);
  endtask
  task automatic t_errs();
    fab.issue(1'b1, 1'b0, CTRL_BASE + 32'ha, '1, r);
    chk("mis", 64'h1, {63'h0, r.error});
    t_version(8'h06);
    fab.issue(1'b0, 1'b1, 32'h3000_0010, 64'h0, r);
    chk("ublk", 64'h3_3000_0010, {30'h0, r.error, debug_err, debug_addr});
    fab.issue(1'b0, 1'b1, 32'h2000_0010, 64'h0, r);
    chk("dblk", 64'h1_2000_0010, {30'h0, r.valid, data_block_valid, data_block_addr});
    t_version(8'h0e);
    fab.pulse_err();
    t_version(8'h0f);
    // software clear and a receive error in the same cycle: the set wins
    fork
      fab.issue(1'b1, 1'b1, CTRL_BASE, 64'h0, r);
      fab.pulse_err();
    join
    t_version(8'h01);
    fab.issue(1'b1, 1'b1, CTRL_BASE, 64'h0, r);
    t_version(8'h00);
  endtask
  initial
  begin
    resetn = 1'b0;
    stat_in = 32'h0;
    repeat (5) @(posedge mclk);
    resetn <= 1'b1;
    t_version(8'h00);
    t_ctrl();
    t_stat();
    t_slots();
    t_errs();
    summarize();
  end
  initial
  begin
    repeat (2000) @(posedge mclk);
    miscompares++;
    summarize();
  end
endmodule
